// ### src/asm_device.sv
`timescale 1ns/100ps
`include "asm_params.svh"
module asm_device (
  input  wire logic              clk,
  input  wire logic              rst_b,
  asm_link_if.dev                link,
  input  wire logic [7:0]        sample_in,
  output logic [7:0]             held_sample,
  output logic                   tracking,
  output logic                   shutdown,
  output logic                   powered,
  output logic                   result_valid
);
  logic                     cs_s;
  logic                     sclk_s;
  logic                     cs_d;
  logic                     sclk_d;
  logic                     in_frame;
  logic [`ASM_CNT_W-1:0]    fall_cnt;
  logic [`ASM_CNT_W-1:0]    rise_cnt;
  logic [`ASM_DATA_W-1:0]   shreg;
  logic                     dout;
  logic                     oe;
  logic                     waking;
  asm_pkg::asm_mode_type    mode;
  logic                     next_cs_d;
  logic                     next_sclk_d;
  logic                     next_in_frame;
  logic [`ASM_CNT_W-1:0]    next_fall_cnt;
  logic [`ASM_CNT_W-1:0]    next_rise_cnt;
  logic [`ASM_DATA_W-1:0]   next_shreg;
  logic                     next_dout;
  logic                     next_oe;
  logic                     next_waking;
  asm_pkg::asm_mode_type    next_mode;
  logic [`ASM_DATA_W-1:0]   next_held;
  logic                     next_tracking;
  logic                     next_powered;
  logic                     next_valid;
  logic                     cs_fall;
  logic                     cs_rise;
  logic                     sck_fall;
  logic                     sck_rise;

  // Mode left behind when select rises, from the falls seen so far
  function automatic asm_pkg::asm_mode_type rise_mode(
    input logic [`ASM_CNT_W-1:0] falls,
    input logic                  wake,
    input asm_pkg::asm_mode_type cur
  );
    asm_pkg::asm_mode_type res;
    res = cur;
    if (falls < `ASM_MODE_EDGE_LO) begin
      res = wake ? asm_pkg::ASM_SHUTDOWN : cur;
    end else if (falls < `ASM_MODE_EDGE_HI) begin
      res = asm_pkg::ASM_SHUTDOWN;
    end
    return res;
  endfunction

  // Falls after which a result bit is shown
  function automatic logic in_data(input logic [`ASM_CNT_W-1:0] falls);
    return (falls >= `ASM_LEAD_ZEROS) && (falls <= `ASM_DATA_LAST);
  endfunction

  // Select and link clock come from the host's clock domain
  asm_sync u_cs (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (link.frame_sel_b),
    .init  (1'b1),
    .dout  (cs_s)
  );
  asm_sync u_sck (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (link.sclk),
    .init  (1'b1),
    .dout  (sclk_s)
  );

  assign cs_fall  = cs_d && !cs_s;
  assign cs_rise  = !cs_d && cs_s;
  assign sck_fall = sclk_d && !sclk_s && !cs_s;
  assign sck_rise = !sclk_d && sclk_s && !cs_s;

  assign link.result_serial_out = dout;
  assign link.result_serial_oe  = oe;
  assign shutdown               = (mode == asm_pkg::ASM_SHUTDOWN);

  // Select edges first, then link clock edges inside a frame
  always_comb begin
    next_cs_d     = cs_s;
    next_sclk_d   = sclk_s;
    next_in_frame = in_frame;
    next_fall_cnt = fall_cnt;
    next_rise_cnt = rise_cnt;
    next_shreg    = shreg;
    next_dout     = dout;
    next_oe       = oe;
    next_waking   = waking;
    next_mode     = mode;
    next_held     = held_sample;
    next_tracking = tracking;
    next_powered  = powered;
    next_valid    = 1'b0;
    if (cs_fall) begin
      next_in_frame = 1'b1;
      next_fall_cnt = '0;
      next_rise_cnt = '0;
      next_mode     = asm_pkg::ASM_NORMAL;
      next_waking   = (mode == asm_pkg::ASM_SHUTDOWN);
      next_held     = sample_in;
      next_shreg    = sample_in;
      next_tracking = 1'b0;
      next_oe       = 1'b1;
      next_dout     = 1'b0;
    end else if (cs_rise && in_frame) begin
      // Select rise ends the frame, early or after the full word
      next_in_frame = 1'b0;
      next_oe       = 1'b0;
      next_dout     = 1'b0;
      next_tracking = 1'b1;
      next_mode     = rise_mode(fall_cnt, waking, mode);
      if (next_mode == asm_pkg::ASM_SHUTDOWN) begin
        next_powered = 1'b0;
      end
    end else if (in_frame) begin
      if (sck_rise) begin
        next_rise_cnt = rise_cnt + 5'h01;
        if (next_rise_cnt == `ASM_TRACK_RISE) begin
          next_tracking = 1'b1;
        end
      end
      if (sck_fall && fall_cnt < `ASM_FRAME_EDGES) begin
        next_fall_cnt = fall_cnt + 5'h01;
        if (next_fall_cnt == `ASM_FRAME_EDGES) begin
          next_oe      = 1'b0;
          next_dout    = 1'b0;
          next_powered = 1'b1;
          next_valid   = !waking && powered;
          next_waking  = 1'b0;
        end else if (in_data(next_fall_cnt)) begin
          next_dout  = shreg[`ASM_DATA_W-1];
          next_shreg = {shreg[`ASM_DATA_W-2:0], 1'b0};
        end else begin
          next_dout = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_d         <= 1'b1;
      sclk_d       <= 1'b1;
      in_frame     <= 1'b0;
      fall_cnt     <= '0;
      rise_cnt     <= '0;
      shreg        <= '0;
      dout         <= 1'b0;
      oe           <= 1'b0;
      waking       <= 1'b1;
      mode         <= asm_pkg::ASM_SHUTDOWN;
      held_sample  <= '0;
      tracking     <= 1'b1;
      powered      <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      cs_d         <= next_cs_d;
      sclk_d       <= next_sclk_d;
      in_frame     <= next_in_frame;
      fall_cnt     <= next_fall_cnt;
      rise_cnt     <= next_rise_cnt;
      shreg        <= next_shreg;
      dout         <= next_dout;
      oe           <= next_oe;
      waking       <= next_waking;
      mode         <= next_mode;
      held_sample  <= next_held;
      tracking     <= next_tracking;
      powered      <= next_powered;
      result_valid <= next_valid;
    end
  end
endmodule

// ### src/asm_host.sv
`timescale 1ns/100ps
`include "asm_params.svh"
// Host end: drives select and a divided serial clock, gathers one word
module asm_host (
  input  wire logic        clk,
  input  wire logic        rst_b,
  asm_link_if.host         link,
  input  wire logic        start,
  input  wire logic [4:0]  stop_after,
  output logic             busy,
  output logic [7:0]       result,
  output logic             result_ready
);
  asm_pkg::asm_host_state_type state;
  asm_pkg::asm_host_state_type next_state;
  logic [7:0]              div;
  logic [7:0]              next_div;
  logic                    sck;
  logic                    next_sck;
  logic [4:0]              edges;
  logic [4:0]              next_edges;
  logic [4:0]              limit;
  logic [4:0]              next_limit;
  logic [15:0]             sh;
  logic [15:0]             next_sh;
  logic [7:0]              next_result;
  logic                    next_ready;
  logic                    sd_s;
  logic                    half;

  asm_sync u_sd (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (link.result_serial_out),
    .init  (1'b0),
    .dout  (sd_s)
  );

  assign link.frame_sel_b = (state != asm_pkg::ASM_H_FRAME);
  assign link.sclk        = sck;
  assign busy             = (state != asm_pkg::ASM_H_IDLE) || start;
  assign half             = (div == `ASM_SCLK_HALF - 8'h01);

  always_comb begin
    next_state  = state;
    next_div    = half ? 8'h00 : div + 8'h01;
    next_sck    = sck;
    next_edges  = edges;
    next_limit  = limit;
    next_sh     = sh;
    next_result = result;
    next_ready  = 1'b0;
    unique case (state)
      asm_pkg::ASM_H_IDLE: begin
        next_sck = 1'b1;
        if (start) begin
          next_state = asm_pkg::ASM_H_FRAME;
          next_div   = 8'h00;
          next_edges = '0;
          next_limit = (stop_after == 5'h00) ? `ASM_FRAME_EDGES : stop_after;
        end
      end
      asm_pkg::ASM_H_FRAME: begin
        if (half) begin
          next_sck = !sck;
          if (sck) begin
            // Falling edge; sampler delay makes the bit two device falls old
            next_edges = edges + 5'h01;
            next_sh    = {sh[14:0], sd_s};
            if (next_edges == limit && limit == `ASM_FRAME_EDGES) begin
              next_result = next_sh[`ASM_RX_MSB:`ASM_RX_LSB];
              next_ready  = 1'b1;
            end
          end else if (edges == limit) begin
            // Select rises with the clock, half a period after the last fall
            next_state = asm_pkg::ASM_H_QUIET;
            next_edges = '0;
          end
        end
      end
      asm_pkg::ASM_H_QUIET: begin
        if (half && !sck) begin
          next_edges = edges + 5'h01;
        end
        if (half) begin
          next_sck = !sck;
        end
        if (edges == `ASM_QUIET_PERIODS) begin
          next_state = asm_pkg::ASM_H_IDLE;
        end
      end
      default: next_state = asm_pkg::ASM_H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= asm_pkg::ASM_H_IDLE;
      div          <= '0;
      sck          <= 1'b1;
      edges        <= '0;
      limit        <= `ASM_FRAME_EDGES;
      sh           <= '0;
      result       <= '0;
      result_ready <= 1'b0;
    end else begin
      state        <= next_state;
      div          <= next_div;
      sck          <= next_sck;
      edges        <= next_edges;
      limit        <= next_limit;
      sh           <= next_sh;
      result       <= next_result;
      result_ready <= next_ready;
    end
  end
endmodule

// ### src/asm_link_if.sv
`timescale 1ns/100ps
interface asm_link_if;
  logic frame_sel_b;
  logic sclk;
  logic result_serial_out;
  logic result_serial_oe;

  modport dev (
    input  frame_sel_b,
    input  sclk,
    output result_serial_out,
    output result_serial_oe
  );
  modport host (
    output frame_sel_b,
    output sclk,
    input  result_serial_out,
    input  result_serial_oe
  );
endinterface

// ### src/asm_params.svh
`ifndef ASM_PARAMS_SVH
`define ASM_PARAMS_SVH
`define ASM_DATA_W        8
`define ASM_CNT_W         5
`define ASM_LEAD_ZEROS    5'h03
`define ASM_DATA_LAST     5'h0b
`define ASM_FRAME_EDGES   5'h10
`define ASM_MODE_EDGE_LO  5'h02
`define ASM_MODE_EDGE_HI  5'h0a
`define ASM_TRACK_RISE    5'h0d
`define ASM_QUIET_PERIODS 5'h04
`define ASM_SCLK_HALF     8'h04
`define ASM_RX_MSB        11
`define ASM_RX_LSB        4
`endif

// ### src/asm_pkg.sv
package asm_pkg;
  typedef enum logic {
    ASM_NORMAL,
    ASM_SHUTDOWN
  } asm_mode_type;

  typedef enum logic [1:0] {
    ASM_H_IDLE,
    ASM_H_FRAME,
    ASM_H_QUIET
  } asm_host_state_type;
endpackage

// ### src/asm_sync.sv
`timescale 1ns/100ps
// Three-stage sampler; change accepted when stages two and three agree
module asm_sync (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic din,
  input  wire logic init,
  output logic      dout
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_dout;

  always_comb begin
    next_stage = {stage[1:0], din};
    next_dout  = (stage[1] == stage[2]) ? stage[2] : dout;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage <= {3{1'b1}};
      dout  <= 1'b1;
    end else begin
      stage <= next_stage;
      dout  <= next_dout;
    end
  end

  logic unused_init;
  assign unused_init = init;
endmodule

// ### tb/asm_link_props.sv
`timescale 1ns/100ps
module asm_link_props (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic frame_sel_b,
  input wire logic sclk,
  input wire logic result_serial_out,
  input wire logic result_serial_oe
);
  logic       sclk_q;
  logic       next_sclk_q;
  logic [4:0] fall_cnt;
  logic [4:0] next_fall_cnt;
  logic [5:0] high_cnt;
  logic [5:0] next_high_cnt;

  // Link falls per frame and select-high run length
  always_comb begin
    next_sclk_q = sclk;
    next_fall_cnt = fall_cnt;
    next_high_cnt = 6'h00;
    if (frame_sel_b) begin
      next_fall_cnt = 5'h00;
    end else if (sclk_q && !sclk && fall_cnt != 5'h1f) begin
      next_fall_cnt = fall_cnt + 5'h01;
    end
    if (frame_sel_b) begin
      next_high_cnt = (high_cnt == 6'h3f) ? high_cnt : high_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
      fall_cnt <= 5'h00;
      high_cnt <= 6'h3f;
    end else begin
      sclk_q <= next_sclk_q;
      fall_cnt <= next_fall_cnt;
      high_cnt <= next_high_cnt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  oe_rise_a: assert property ($fell(frame_sel_b) |-> ##[1:8] result_serial_oe)
    else $error("output not driven after select fall");
  oe_release_a: assert property ($rose(frame_sel_b) |-> ##[0:8] !result_serial_oe)
    else $error("output not floated after select rise");
  oe_idle_a: assert property (high_cnt >= 6'h08 |-> !result_serial_oe)
    else $error("output driven while select idle");
  frame_len_a: assert property (fall_cnt <= 5'h10)
    else $error("more than sixteen clock falls in a frame");
  lead_zero_a: assert property (!frame_sel_b && result_serial_oe && fall_cnt <= 5'h02
    |-> !result_serial_out)
    else $error("leading bit not zero");
  trail_zero_a: assert property (!frame_sel_b && result_serial_oe && fall_cnt >= 5'h0c
    |-> !result_serial_out)
    else $error("trailing bit not zero");
  sclk_rate_a: assert property ($rose(sclk) && !frame_sel_b |-> sclk [*4])
    else $error("serial clock high phase too short");
  quiet_gap_a: assert property ($fell(frame_sel_b) |-> high_cnt >= 6'h1f)
    else $error("quiet interval too short");
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic       clk;
  logic       rst_b;
  logic       start;
  logic [4:0] stop_after;
  logic [7:0] sample_in;
  logic [7:0] held_sample;
  logic       tracking;
  logic       shutdown;
  logic       powered;
  logic       result_valid;
  logic       busy;
  logic [7:0] result;
  logic       result_ready;
  logic       got_ready;
  logic       got_valid;
  logic       saw_hold;
  int         failures;
  int         checks_done;

  asm_link_if link ();
  asm_device asm_device_inst (.clk(clk), .rst_b(rst_b), .link(link), .sample_in(sample_in),
    .held_sample(held_sample), .tracking(tracking), .shutdown(shutdown),
    .powered(powered), .result_valid(result_valid));
  asm_host asm_host_inst (.clk(clk), .rst_b(rst_b), .link(link), .start(start),
    .stop_after(stop_after), .busy(busy), .result(result), .result_ready(result_ready));
  asm_link_props asm_link_props_inst (.clk(clk), .rst_b(rst_b),
    .frame_sel_b(link.frame_sel_b), .sclk(link.sclk),
    .result_serial_out(link.result_serial_out), .result_serial_oe(link.result_serial_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (result_ready === 1'b1) got_ready <= 1'b1;
    if (result_valid === 1'b1) got_valid <= 1'b1;
    if (busy === 1'b1 && tracking === 1'b0) saw_hold <= 1'b1;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One frame from the host, then the end state of both ends
  task automatic run(input logic [4:0] stop, input logic [7:0] smp, input logic sd,
                     input logic rdy, input logic vld);
    int n;
    @(negedge clk);
    sample_in = smp;
    stop_after = stop;
    start = 1'b1;
    got_ready = 1'b0;
    got_valid = 1'b0;
    saw_hold = 1'b0;
    @(negedge clk);
    start = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n == 400) begin
      failures++;
      close_out();
    end
    check("shutdown", 8'(shutdown), 8'(sd));
    check("ready", 8'(got_ready), 8'(rdy));
    check("valid", 8'(got_valid), 8'(vld));
    check("held", held_sample, smp);
    check("hold", 8'(saw_hold), 8'h01);
    check("track", 8'(tracking), 8'h01);
    if (vld) check("result", result, smp);
  endtask

  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    stop_after = 5'h00;
    sample_in = 8'h00;
    got_ready = 1'b0;
    got_valid = 1'b0;
    saw_hold = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    check("start mode", 8'(shutdown), 8'h01);
    check("start power", 8'(powered), 8'h00);
    run(5'h00, 8'ha5, 1'b0, 1'b1, 1'b0);
    check("powered", 8'(powered), 8'h01);
    run(5'h00, 8'h80, 1'b0, 1'b1, 1'b1);
    run(5'h00, 8'h01, 1'b0, 1'b1, 1'b1);
    run(5'h00, 8'h3c, 1'b0, 1'b1, 1'b1);
    run(5'h01, 8'h55, 1'b0, 1'b0, 1'b0);
    run(5'h0a, 8'h5a, 1'b0, 1'b0, 1'b0);
    run(5'h0f, 8'hc3, 1'b0, 1'b0, 1'b0);
    run(5'h00, 8'h0f, 1'b0, 1'b1, 1'b1);
    run(5'h02, 8'h44, 1'b1, 1'b0, 1'b0);
    run(5'h01, 8'h22, 1'b1, 1'b0, 1'b0);
    run(5'h09, 8'h11, 1'b1, 1'b0, 1'b0);
    run(5'h00, 8'h66, 1'b0, 1'b1, 1'b0);
    run(5'h00, 8'hff, 1'b0, 1'b1, 1'b1);
    run(5'h09, 8'h99, 1'b1, 1'b0, 1'b0);
    close_out();
  end
endmodule
